/* logic/stepper_drive_control.sv */
// Step/direction sequencer, current setting, idle reduction and self-test.
// Assumes pins come from opto inputs (asynchronous) and an AXI4-Lite master.
`timescale 1ns/100ps

// How it works
// - disable pin high switches amplifiers off
// - position keeps counting while amplifiers off
// - floating disable pin reads low, enabled
// - reset puts sequencer at index 0
// - current is 0.4 A plus switch weights
// - half, 1/5, 1/10, 1/50 resolutions
// - both resolution bits set selects 1/10
// - idle halves current, stepping restores it
// - idle bit enables reduction, else full
// - self-test swings half turn each way
// - self-test always uses half steps
// - self-test ignores step and direction
// - self-test off after reset
// - step on falling edge, 0.5 us pulses
// - idle current after 1 s rest
// - self-test steps at 100 per second
module stepper_drive_control
  import stepper_pkg::*;
#(
  parameter int TEST_CYCLES = stepper_pkg::TEST_CYC,
  parameter int IDLE_CYCLES = stepper_pkg::IDLE_CYC
)(
  input wire logic clock,
  input wire logic rstn,
  input wire stepper_pkg::axil_req_t axiReq,
  output stepper_pkg::axil_rsp_t axiRsp,
  input wire stepper_pkg::pins_t pins,
  output stepper_pkg::drive_t drive
);
  import stepper_pkg::*;

  localparam int TW = $clog2(TEST_CYCLES + 1);
  localparam int IW = $clog2(IDLE_CYCLES + 1);
  localparam logic [TW-1:0] TEST_LAST = TW'(TEST_CYCLES - 1);
  localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_CYCLES - 1);
  localparam logic [7:0] HALF_REV_LAST = 8'(HALF_REV_STEPS - 1);

  typedef struct packed {
    axil_rsp_t rsp;
    drive_t drv;
    ctrl_t ctrl;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [2:0] stepS;
    logic [1:0] dirS;
    logic [1:0] disS;
    test_t test;
    logic [TW-1:0] testCnt;
    logic [7:0] testSteps;
    logic [IW-1:0] idleCnt;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic stepEv;
  logic extStep;
  logic testStep;
  logic moveUp;
  logic [7:0] tableLen;
  logic [6:0] fullCur;

  // ==========================================================================
  // Helpers
  // Electrical cycle length: four full steps times the subdivision
  function automatic logic [7:0] cycleLen(input res_t r);
    unique case (r)
      RES_HALF: cycleLen = 8'h08;
      RES_FIFTH: cycleLen = 8'h14;
      RES_TENTH: cycleLen = 8'h28;
      RES_FIFTIETH: cycleLen = 8'hC8;
    endcase
  endfunction

  // 0 = control, 1 = status, 2 = unmapped
  function automatic logic [1:0] regSel(input logic [7:0] a);
    if (a[7:2] == ADDR_CTRL[7:2])
    begin
      regSel = 2'h0;
    end
    else if (a[7:2] == ADDR_STATUS[7:2])
    begin
      regSel = 2'h1;
    end
    else
    begin
      regSel = 2'h2;
    end
  endfunction

  assign stepEv = st_r.stepS[2] & ~st_r.stepS[1];
  assign extStep = stepEv & ~st_r.ctrl.selfTest;
  assign testStep = (st_r.test != T_OFF) && (st_r.testCnt == TEST_LAST);
  assign moveUp = st_r.ctrl.selfTest ? (st_r.test == T_FWD) : st_r.dirS[1];
  assign tableLen = st_r.ctrl.selfTest ? 8'(HALF_TABLE_LEN) : cycleLen(st_r.ctrl.res);
  assign fullCur = 7'(({2'h0, st_r.ctrl.curCode} + BASE_CUR) << 1);

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    // Opto inputs: first flop feeds only the second
    st_nxt.stepS = {st_r.stepS[1:0], pins.stepPulse};
    st_nxt.dirS = {st_r.dirS[0], pins.dirLevel};
    st_nxt.disS = {st_r.disS[0], pins.disableLevel};

    // AXI write: address and data taken in either order
    if (axiReq.awvalid && st_r.rsp.awready)
    begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && st_r.rsp.wready)
    begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = axiReq.wdata;
      st_nxt.wStrb = axiReq.wstrb;
    end
    if (st_r.rsp.bvalid && axiReq.bready)
    begin
      st_nxt.rsp.bvalid = 1'b0;
    end
    if (st_nxt.awHeld && st_nxt.wHeld && !st_r.rsp.bvalid)
    begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      st_nxt.rsp.bresp = (regSel(st_nxt.awAddr) == 2'h2) ? RESP_SLVERR : RESP_OKAY;
      // Lane 0 holds the low control byte, lane 1 the top current bit
      if (regSel(st_nxt.awAddr) == 2'h0 && st_nxt.wStrb[0])
      begin
        st_nxt.ctrl[7:0] = st_nxt.wData[7:0];
      end
      if (regSel(st_nxt.awAddr) == 2'h0 && st_nxt.wStrb[1])
      begin
        st_nxt.ctrl[8] = st_nxt.wData[8];
      end
    end
    st_nxt.rsp.awready = !st_nxt.awHeld && !st_nxt.rsp.bvalid;
    st_nxt.rsp.wready = !st_nxt.wHeld && !st_nxt.rsp.bvalid;

    // AXI read
    if (st_r.rsp.rvalid && axiReq.rready)
    begin
      st_nxt.rsp.rvalid = 1'b0;
    end
    if (axiReq.arvalid && st_r.rsp.arready)
    begin
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rresp = RESP_OKAY;
      unique case (regSel(axiReq.araddr))
        2'h0: st_nxt.rsp.rdata = {23'h000000, st_r.ctrl};
        2'h1: st_nxt.rsp.rdata = status_t'{9'h000, st_r.drv.curLevel, 5'h00,
          st_r.test == T_BWD, st_r.drv.ampOn, st_r.drv.idle, st_r.drv.posIdx};
        default:
        begin
          st_nxt.rsp.rdata = 32'h00000000;
          st_nxt.rsp.rresp = RESP_SLVERR;
        end
      endcase
    end
    st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

    // Self-test sequencer
    unique case (st_r.test)
      T_OFF:
      begin
        st_nxt.testCnt = '0;
        st_nxt.testSteps = 8'h00;
        if (st_r.ctrl.selfTest)
        begin
          st_nxt.test = T_FWD;
        end
      end
      T_FWD, T_BWD:
      begin
        st_nxt.testCnt = testStep ? '0 : TW'(st_r.testCnt + 1'b1);
        if (testStep)
        begin
          st_nxt.testSteps = (st_r.testSteps == HALF_REV_LAST) ? 8'h00 : 8'(st_r.testSteps + 1'b1);
          if (st_r.testSteps == HALF_REV_LAST)
          begin
            st_nxt.test = (st_r.test == T_FWD) ? T_BWD : T_FWD;
          end
        end
        if (!st_r.ctrl.selfTest)
        begin
          st_nxt.test = T_OFF;
        end
      end
      default: st_nxt.test = T_OFF;
    endcase

    // Phase index, also while amplifiers are off
    if (extStep || testStep)
    begin
      if (moveUp)
      begin
        st_nxt.drv.posIdx = (st_r.drv.posIdx >= 8'(tableLen - 1'b1)) ? 8'h00
          : 8'(st_r.drv.posIdx + 1'b1);
      end
      else
      begin
        st_nxt.drv.posIdx = (st_r.drv.posIdx == 8'h00 || st_r.drv.posIdx >= tableLen)
          ? 8'(tableLen - 1'b1) : 8'(st_r.drv.posIdx - 1'b1);
      end
    end

    // Rest timer; any step restarts full current
    if (extStep || testStep)
    begin
      st_nxt.idleCnt = '0;
      st_nxt.drv.idle = 1'b0;
    end
    else if (st_r.idleCnt == IDLE_LAST)
    begin
      st_nxt.drv.idle = 1'b1;
    end
    else
    begin
      st_nxt.idleCnt = IW'(st_r.idleCnt + 1'b1);
    end

    st_nxt.drv.curLevel = (st_r.ctrl.idleEn && st_r.drv.idle) ? (fullCur >> 1)
      : fullCur;
    // Undriven opto reads low, so amplifiers stay on
    st_nxt.drv.ampOn = !st_r.disS[1];
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RESET;
      st_r.test <= T_OFF;
      st_r.drv.posIdx <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign axiRsp = st_r.rsp;
  assign drive = st_r.drv;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence extUpStep;
    extStep && st_r.dirS[1];
  endsequence

  sequence testHalfDone;
    testStep && st_r.testSteps == HALF_REV_LAST;
  endsequence

  a_disable_cuts: assert property (st_r.disS[1] |=> !drive.ampOn)
    else $error("amplifiers on while disabled");
  a_disabled_counts: assert property (extStep && st_r.disS[1] |=> $changed(drive.posIdx))
    else $error("position lost while disabled");
  a_open_enabled: assert property (!st_r.disS[1] [*2] |=> drive.ampOn)
    else $error("amplifiers off with disable low");
  a_reset_index: assert property (disable iff (1'b0) !rstn |=> drive.posIdx == 8'h00 && !st_r.ctrl.selfTest)
    else $error("bad state after reset");
  a_current_full: assert property (!st_r.drv.idle |=> drive.curLevel == $past(fullCur))
    else $error("moving current wrong");
  a_fiftieth_wrap: assert property (extUpStep ##0 (st_r.ctrl.res == RES_FIFTIETH
    && st_r.drv.posIdx == 8'hC7) |=> drive.posIdx == 8'h00)
    else $error("1/50 table does not wrap at 200");
  a_tenth_wrap: assert property (extUpStep ##0 (st_r.ctrl.res == RES_TENTH
    && st_r.drv.posIdx == 8'h27) |=> drive.posIdx == 8'h00)
    else $error("1/10 table does not wrap at 40");
  a_idle_half: assert property (st_r.ctrl.idleEn && st_r.drv.idle
    |=> drive.curLevel == ($past(fullCur) >> 1))
    else $error("idle current not halved");
  a_no_reduce: assert property (!st_r.ctrl.idleEn |=> drive.curLevel == $past(fullCur))
    else $error("current reduced while disabled");
  a_test_turn: assert property (testHalfDone |=> st_r.test != $past(st_r.test))
    else $error("self-test did not reverse");
  a_test_half: assert property (testStep && st_r.test == T_FWD && st_r.drv.posIdx == 8'h07
    |=> drive.posIdx == 8'h00)
    else $error("self-test not in half steps");
  a_test_ignores: assert property (st_r.ctrl.selfTest && stepEv && !testStep
    |=> $stable(drive.posIdx))
    else $error("external step taken in self-test");
  a_idle_wait: assert property (drive.idle |-> st_r.idleCnt == IDLE_LAST)
    else $error("idle before rest time");
  a_test_rate: assert property (testStep |=> !testStep [*2])
    else $error("self-test steps too close");
  a_index_up: assert property (extUpStep ##0 (st_r.drv.posIdx < 8'(tableLen - 1'b1))
    |=> drive.posIdx == 8'($past(drive.posIdx) + 1'b1))
    else $error("index did not advance by one");

  // ==========================================================================
  // Register and sequencing checks
  sequence ctrlWrite;
    st_nxt.awHeld && st_nxt.wHeld && !st_r.rsp.bvalid && regSel(st_nxt.awAddr) == 2'h0;
  endsequence

  sequence extDownStep;
    extStep && !st_r.dirS[1];
  endsequence

  a_top_lane: assert property (ctrlWrite ##0 st_nxt.wStrb[1]
    |=> st_r.ctrl[8] == $past(st_nxt.wData[8]))
    else $error("top current bit not written");
  a_low_lane: assert property (ctrlWrite ##0 !st_nxt.wStrb[0]
    |=> st_r.ctrl[7:0] == $past(st_r.ctrl[7:0]))
    else $error("control byte changed without its strobe");
  a_down_wrap: assert property (extDownStep ##0 st_r.drv.posIdx == 8'h00
    |=> drive.posIdx == 8'($past(tableLen) - 1'b1))
    else $error("index did not wrap to table end");
  a_index_down: assert property (extDownStep ##0 (st_r.drv.posIdx != 8'h00
    && st_r.drv.posIdx < tableLen) |=> drive.posIdx == 8'($past(drive.posIdx) - 1'b1))
    else $error("index did not go back by one");
  a_step_full: assert property ((extStep || testStep) |=> !drive.idle)
    else $error("idle kept while stepping");
  a_idle_sets: assert property (!extStep && !testStep && st_r.idleCnt == IDLE_LAST |=> drive.idle)
    else $error("idle not flagged after rest time");
  a_test_start: assert property (st_r.test == T_OFF && st_r.ctrl.selfTest |=> st_r.test == T_FWD)
    else $error("self-test did not start forward");
  a_test_stop: assert property (!st_r.ctrl.selfTest |=> st_r.test == T_OFF)
    else $error("self-test runs while switched off");
  // Only one answer of each kind may be pending
  a_one_write: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write accepted while response pending");
  a_one_read: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read accepted while data pending");
endmodule

/* logic/stepper_pkg.sv */
// Constants, register layouts and carrier types of the step-motor control logic.
// Assumes a single 125 MHz clock and an AXI4-Lite master with 32-bit data.
package stepper_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int TEST_RATE_HZ = 100;
  localparam int IDLE_WAIT_S = 1;
  localparam int TEST_CYC = CLK_HZ / TEST_RATE_HZ;
  localparam int IDLE_CYC = CLK_HZ * IDLE_WAIT_S;
  localparam int HALF_REV_STEPS = 200;
  localparam int HALF_TABLE_LEN = 8;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Current code in 0.1 A units, doubled to 0.05 A units on the drive; base 0.4 A
  localparam logic [6:0] BASE_CUR = 7'h04;

  typedef enum logic [1:0] {
    RES_HALF = 2'h0,
    RES_FIFTH = 2'h1,
    RES_FIFTIETH = 2'h2,
    RES_TENTH = 2'h3
  } res_t;

  typedef enum logic [2:0] {
    T_OFF = 3'h1,
    T_FWD = 3'h2,
    T_BWD = 3'h4
  } test_t;

  typedef struct packed {
    logic [4:0] curCode;
    logic idleEn;
    res_t res;
    logic selfTest;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 9'h008;

  typedef struct packed {
    logic [8:0] zeroHi;
    logic [6:0] curLevel;
    logic [4:0] zeroLo;
    logic testBack;
    logic ampOn;
    logic idle;
    logic [7:0] pos;
  } status_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic stepPulse;
    logic dirLevel;
    logic disableLevel;
  } pins_t;

  typedef struct packed {
    logic ampOn;
    logic [7:0] posIdx;
    logic [6:0] curLevel;
    logic idle;
  } drive_t;
endpackage

/* dv/stepper_indexer_model.sv */
// Indexer model: drives the step, direction and disable pins of the drive.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/100ps
module stepper_indexer_model
  import stepper_pkg::*;
#(
  parameter int PULSE_CYC = 63,
  parameter int DIR_SETUP = 250
)(
  input wire logic clock,
  output stepper_pkg::pins_t pins
);
  // ==========================================================================
  // Pin drivers
  initial pins = '0;

  // Direction settles well before the falling edge that moves the motor
  task automatic step(input logic up);
    if (pins.dirLevel !== up)
    begin
      pins.dirLevel <= up;
      repeat (DIR_SETUP) @(posedge clock);
    end
    pins.stepPulse <= 1'b1;
    repeat (PULSE_CYC) @(posedge clock);
    pins.stepPulse <= 1'b0;
    repeat (PULSE_CYC) @(posedge clock);
  endtask

  task automatic setDisable(input logic v);
    pins.disableLevel <= v;
    @(posedge clock);
  endtask
endmodule

/* dv/test_stepper_drive_control_logic.sv */
// Testbench of the step-motor control logic with an indexer model on the pins.
// Assumes short self-test and idle counts given through the parameters.
`timescale 1ns/100ps
module test_stepper_drive_control_logic;
  import stepper_pkg::*;
  logic clock;
  logic rstn;
  axil_req_t req;
  axil_rsp_t rsp;
  pins_t pins;
  drive_t drive;
  int mismatches;
  int samples_checked;
  logic [31:0] rdat;
  logic [1:0] resp;
  logic [31:0] seed;
  logic [7:0] expPos;
  logic [4:0] cc;
  logic [3:0] strb;
  int tabLen[4] = '{8, 20, 200, 40};

  stepper_drive_control #(.TEST_CYCLES(20), .IDLE_CYCLES(100)) dut (.clock(clock), .rstn(rstn),
    .axiReq(req), .axiRsp(rsp), .pins(pins), .drive(drive));
  stepper_indexer_model ix (.clock(clock), .pins(pins));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] full(input logic [4:0] c);
    return 8'(2 * (4 + c));
  endfunction

  task automatic wrap_up;
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One transfer; waits are bounded and a hang ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (w)
    begin
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= strb;
      req.bready <= 1'b1;
    end
    else
    begin
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
    end
    do
    begin
      @(posedge clock);
      n++;
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (n > 50)
      begin
        mismatches++;
        wrap_up();
      end
    end while (!(w ? rsp.bvalid === 1'b1 : rsp.rvalid === 1'b1));
    resp = w ? rsp.bresp : rsp.rresp;
    rdat = rsp.rdata;
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic steps(input int k, input logic up, input int len);
    repeat (k)
    begin
      ix.step(up);
      expPos = up ? ((expPos == len - 1) ? 8'h00 : expPos + 8'h01)
                  : ((expPos == 8'h00) ? 8'(len - 1) : expPos - 8'h01);
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    req = '0;
    strb = 4'hF;
    rstn = 1'b0;
    seed = 32'h80C237FA;
    mismatches = 0;
    samples_checked = 0;
    expPos = 8'h00;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl reset", rdat, 32'h0000_0008);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("status reset", rdat, 32'h0008_0200);
    bus(1'b0, 8'h0C, 32'h0);
    check("unmapped read", {rdat[7:0], resp}, 10'h002);
    bus(1'b1, 8'h0C, 32'h0);
    check("unmapped write", resp, RESP_SLVERR);
    bus(1'b1, ADDR_STATUS, 32'hFF);
    check("status write", resp, RESP_OKAY);
    for (int r = 0; r < 4; r++)
    begin
      seed = lfsr(seed);
      cc = seed[4:0];
      bus(1'b1, ADDR_CTRL, {seed[31:9], cc, 1'b0, 2'(r), 1'b0});
      repeat (6) @(posedge clock);
      check("current", drive.curLevel, full(cc));
      steps(tabLen[r], 1'b1, tabLen[r]);
      check("wrap up", drive.posIdx, expPos);
      steps(1, 1'b0, tabLen[r]);
      check("wrap down", drive.posIdx, expPos);
      steps(1, 1'b1, tabLen[r]);
    end
    // Lane 1 only: top current bit flips, low byte must stay
    strb = 4'h2;
    bus(1'b1, ADDR_CTRL, {23'h0, ~cc[4], 8'h00});
    strb = 4'hF;
    cc[4] = ~cc[4];
    bus(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl lanes", rdat, {23'h0, cc, 4'h6});
    check("current top", drive.curLevel, full(cc));
    repeat (8)
    begin
      seed = lfsr(seed);
      steps(1, seed[0], 40);
    end
    check("random walk", drive.posIdx, expPos);
    ix.setDisable(1'b1);
    repeat (6) @(posedge clock);
    check("amp off", drive.ampOn, 1'b0);
    steps(1, 1'b1, 40);
    check("pos kept", drive.posIdx, expPos);
    ix.setDisable(1'b0);
    repeat (6) @(posedge clock);
    check("amp on", drive.ampOn, 1'b1);
    bus(1'b1, ADDR_CTRL, {23'h0, cc, 4'hE});
    repeat (120) @(posedge clock);
    check("idle cur", {drive.idle, drive.curLevel}, {1'b1, 7'(4 + cc)});
    steps(1, 1'b1, 40);
    check("moving cur", {drive.idle, drive.curLevel}, {1'b0, 7'(full(cc))});
    check("idle step pos", drive.posIdx, expPos);
    bus(1'b1, ADDR_CTRL, {23'h0, cc, 4'h6});
    repeat (120) @(posedge clock);
    check("no reduce", drive.curLevel, full(cc));
    bus(1'b1, ADDR_CTRL, {23'h0, cc, 4'h7});
    repeat (4100) @(posedge clock);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("test back", {rdat[10], rdat[7:3]}, 6'h20);
    ix.setDisable(1'b1);
    repeat (6) @(posedge clock);
    check("test amp off", drive.ampOn, 1'b0);
    ix.setDisable(1'b0);
    ix.step(1'b1);
    repeat (3800) @(posedge clock);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("test fwd", {rdat[10], rdat[7:3]}, 6'h00);
    // Reset in mid-run, while self-test is moving the motor
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    check("reset pos", drive.posIdx, 8'h00);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check("reset ctrl", rdat, 32'h0000_0008);
    wrap_up();
  end

  initial
  begin
    repeat (100000) @(posedge clock);
    mismatches++;
    wrap_up();
  end
endmodule
